// *** rtl/dsc_core_pkg.sv ***
// Purpose: Shared constants for the core register model
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes:   Byte offsets, status field positions and reset values
package dsc_core_pkg;
	// Widths
	localparam int IP_W   = 23;
	localparam int NUM_W  = 16;
	localparam int NUM_IRQ = 54;
	localparam int NUM_TRAP = 8;
	// Register byte offsets
	localparam logic [11:0] OFF_WREG    = 12'h000;
	localparam logic [11:0] OFF_STATUS  = 12'h040;
	localparam logic [11:0] OFF_TBLPG   = 12'h044;
	localparam logic [11:0] OFF_PSVPG   = 12'h048;
	localparam logic [11:0] OFF_LPBEGIN = 12'h04C;
	localparam logic [11:0] OFF_LPEND   = 12'h050;
	localparam logic [11:0] OFF_LPCNT   = 12'h054;
	localparam logic [11:0] OFF_RPCNT   = 12'h058;
	localparam logic [11:0] OFF_IP      = 12'h05C;
	localparam logic [11:0] OFF_CTRL    = 12'h060;
	localparam logic [11:0] OFF_MODBEG  = 12'h064;
	localparam logic [11:0] OFF_MODEND  = 12'h068;
	localparam logic [11:0] OFF_EXC     = 12'h06C;
	localparam logic [3:0]  PRIO_PAGE   = 4'h1;
	// Status word fields
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_OV = 2;
	localparam int ST_N = 3;
	localparam int ST_RA = 4;
	localparam int ST_PRI = 5;
	localparam int ST_DC = 8;
	localparam int ST_DA = 9;
	localparam logic [15:0] FLAG_MASK = 16'h010F;
	// Control fields
	localparam int CT_MODX = 0;
	localparam int CT_MODY = 1;
	localparam int CT_BREV = 2;
	localparam int CT_PSV = 3;
	// Reset values and fixed figures
	localparam logic [15:0] SP_RESET   = 16'h0800;
	localparam logic [15:0] Y_BASE     = 16'h0900;
	localparam logic [15:0] Y_LAST     = 16'h0BFF;
	localparam logic [15:0] WORD_STEP  = 16'h0002;
	localparam logic [22:0] IP_STEP    = 23'h000002;
	localparam logic [3:0]  TRAP_TOP   = 4'hF;
	localparam logic [4:0]  SHR_MAX    = 5'h0F;
	localparam logic [4:0]  SHL_MAX    = 5'h10;
	localparam logic [3:0]  SP_IDX     = 4'hF;
	localparam logic [3:0]  FP_IDX     = 4'hE;
endpackage

// *** rtl/dsc_core_regs.sv ***
// Purpose: Programmer-visible state of a 16-bit DSC core
// Assumes: Core control events arrive on mclk; AHB-Lite slave
// Notes:   Reads take one wait state, writes none
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module dsc_core_regs (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Core register write port
	input  wire logic        coreWr,
	input  wire logic [3:0]  coreWrIdx,
	input  wire logic [15:0] coreWrData,
	input  wire logic        coreWrByte,
	// Core events
	input  wire logic        shadowPush,
	input  wire logic        shadowPop,
	input  wire logic        loopStart,
	input  wire logic [22:0] loopBeginIn,
	input  wire logic [22:0] loopEndIn,
	input  wire logic [13:0] loopCountIn,
	input  wire logic        loopDone,
	input  wire logic        repeatStart,
	input  wire logic [13:0] repeatCountIn,
	input  wire logic        repeatTick,
	input  wire logic        callPush,
	input  wire logic        retPop,
	input  wire logic        frameLink,
	input  wire logic        frameUnlink,
	// Barrel shift of a working register
	input  wire logic        shiftReq,
	input  wire logic [3:0]  shiftIdx,
	input  wire logic        shiftLeft,
	input  wire logic [4:0]  shiftAmt,
	// Address generation
	input  wire logic        aguStep,
	input  wire logic [3:0]  aguIdx,
	input  wire logic        aguY,
	input  wire logic        aguDest,
	input  wire logic [15:0] dataAddr,
	input  wire logic [3:0]  tblIdx,
	// Fetch
	input  wire logic        fetchStep,
	input  wire logic [23:0] fetchWord,
	input  wire logic        ipLoad,
	input  wire logic [22:0] ipLoadVal,
	// Exceptions
	input  wire logic [7:0]  trapReq,
	input  wire logic [53:0] irqReq,
	input  wire logic        excAck,
	// Outputs to the core
	output logic      [22:0] fetchAddr,
	output logic      [23:0] instrNext,
	output logic             stackWr,
	output logic      [15:0] stackWrAddr,
	output logic      [15:0] stackWrData,
	output logic             dataIsY,
	output logic             psvHit,
	output logic      [22:0] psvAddr,
	output logic      [23:0] tblAddr,
	output logic             excReq,
	output logic      [5:0]  excVector
);
	typedef struct packed {
		logic [15:0][15:0] wreg;
		logic [15:0]       status;
		logic [7:0]        tblPage;
		logic [7:0]        psvPage;
		logic [22:0]       loopBegin;
		logic [22:0]       loopEnd;
		logic [13:0]       loopCount;
		logic [13:0]       repCount;
		logic [22:0]       ip;
		logic [15:0]       ctrl;
		logic [15:0]       modBeg;
		logic [15:0]       modEnd;
		logic [53:0][2:0]  prio;
		logic [3:0][15:0]  shW;
		logic [15:0]       shFlags;
		logic [22:0]       shBegin;
		logic [22:0]       shEnd;
		logic [13:0]       shCount;
		logic              dWr;
		logic              dRd;
		logic [11:0]       dAddr;
		logic [3:0]        dLanes;
		logic [31:0]       rdata;
		logic              ready;
		logic [22:0]       fetchAddr;
		logic [23:0]       instrNext;
		logic              stackWr;
		logic [15:0]       stackWrAddr;
		logic [15:0]       stackWrData;
		logic              dataIsY;
		logic              psvHit;
		logic [22:0]       psvAddr;
		logic [23:0]       tblAddr;
		logic              excReq;
		logic [5:0]        excVector;
		logic [3:0]        excPri;
	} state_t;

	state_t      st;
	state_t      next_st;
	logic [1:0]  rstSync;
	logic        rstLocal_n;

	// Reset release through two flip-flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync <= 2'b00;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstLocal_n = rstSync[1];

	// Bus read mux over the visible map; shadows have no address
	function automatic logic [31:0] readReg(state_t s, logic [11:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a[11:8] == dsc_core_pkg::PRIO_PAGE) begin
			if (a[7:2] < 6'(dsc_core_pkg::NUM_IRQ))
				r = {29'h0, s.prio[a[7:2]]};
		end else if (a[11:6] == 6'h00) begin
			r = {16'h0, s.wreg[a[5:2]]};
		end else begin
			case (a)
				dsc_core_pkg::OFF_STATUS:  r = {16'h0, s.status};
				dsc_core_pkg::OFF_TBLPG:   r = {24'h0, s.tblPage};
				dsc_core_pkg::OFF_PSVPG:   r = {24'h0, s.psvPage};
				dsc_core_pkg::OFF_LPBEGIN: r = {9'h0, s.loopBegin};
				dsc_core_pkg::OFF_LPEND:   r = {9'h0, s.loopEnd};
				dsc_core_pkg::OFF_LPCNT:   r = {18'h0, s.loopCount};
				dsc_core_pkg::OFF_RPCNT:   r = {18'h0, s.repCount};
				dsc_core_pkg::OFF_IP:      r = {9'h0, s.ip};
				dsc_core_pkg::OFF_CTRL:    r = {16'h0, s.ctrl};
				dsc_core_pkg::OFF_MODBEG:  r = {16'h0, s.modBeg};
				dsc_core_pkg::OFF_MODEND:  r = {16'h0, s.modEnd};
				dsc_core_pkg::OFF_EXC:
					r = {21'h0, s.excPri, s.excReq, s.excVector};
				default:                   r = 32'h0000_0000;
			endcase
		end
		return r;
	endfunction

	// Byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(logic [15:0] o,
		logic [15:0] n, logic [1:0] ln);
		return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
	endfunction

	// Next-state logic: bus, core events, prefetch, arbitration
	always_comb begin
		logic [15:0] p;
		logic [15:0] m;
		logic [15:0] sw;
		logic [3:0]  bestPri;
		logic [5:0]  bestVec;
		logic        found;
		logic [2:0]  wl;
		next_st = st;
		p = 16'h0;
		m = 16'h0;
		sw = 16'h0;
		bestPri = 4'h0;
		bestVec = 6'h00;
		found = 1'b0;
		wl = 3'h0;
		next_st.stackWr = 1'b0;
		next_st.ready = 1'b1;
		// Bus data phase: write lanes, or read after one wait state
		if (st.dWr) begin
			if (st.dAddr[11:8] == dsc_core_pkg::PRIO_PAGE) begin
				if (st.dAddr[7:2] < 6'(dsc_core_pkg::NUM_IRQ)
					&& st.dLanes[0])
					next_st.prio[st.dAddr[7:2]] = hwdata[2:0];
			end else if (st.dAddr[11:6] == 6'h00) begin
				next_st.wreg[st.dAddr[5:2]] = merge16(
					st.wreg[st.dAddr[5:2]], hwdata[15:0],
					st.dLanes[1:0]);
			end else begin
				case (st.dAddr)
					dsc_core_pkg::OFF_STATUS: next_st.status =
						merge16(st.status, hwdata[15:0], st.dLanes[1:0]);
					dsc_core_pkg::OFF_TBLPG: if (st.dLanes[0])
						next_st.tblPage = hwdata[7:0];
					dsc_core_pkg::OFF_PSVPG: if (st.dLanes[0])
						next_st.psvPage = hwdata[7:0];
					dsc_core_pkg::OFF_LPBEGIN: next_st.loopBegin =
						{hwdata[22:1], 1'b0};
					dsc_core_pkg::OFF_LPEND: next_st.loopEnd =
						{hwdata[22:1], 1'b0};
					dsc_core_pkg::OFF_LPCNT: next_st.loopCount = hwdata[13:0];
					dsc_core_pkg::OFF_RPCNT: next_st.repCount = hwdata[13:0];
					dsc_core_pkg::OFF_IP: next_st.ip = {hwdata[22:1], 1'b0};
					dsc_core_pkg::OFF_CTRL: next_st.ctrl =
						merge16(st.ctrl, hwdata[15:0], st.dLanes[1:0]);
					dsc_core_pkg::OFF_MODBEG: next_st.modBeg = hwdata[15:0];
					dsc_core_pkg::OFF_MODEND: next_st.modEnd = hwdata[15:0];
					default: next_st.ip = next_st.ip;
				endcase
			end
		end
		if (st.dRd)
			next_st.rdata = readReg(st, st.dAddr);
		// Address phase capture
		next_st.dWr = 1'b0;
		next_st.dRd = 1'b0;
		if (hsel && htrans[1] && hready) begin
			next_st.dAddr = {haddr[11:2], 2'b00};
			wl = hsize;
			next_st.dLanes = (wl == 3'h0) ? 4'(1 << haddr[1:0]) :
				(wl == 3'h1) ? (haddr[1] ? 4'hC : 4'h3) : 4'hF;
			next_st.dWr = hwrite;
			next_st.dRd = !hwrite;
			next_st.ready = hwrite;
		end
		// Core write port; byte form keeps the high byte
		if (coreWr)
			next_st.wreg[coreWrIdx] = coreWrByte ?
				{st.wreg[coreWrIdx][15:8], coreWrData[7:0]} :
				coreWrData;
		// Barrel shift, limited to 15 right and 16 left
		if (shiftReq) begin
			sw = st.wreg[shiftIdx];
			if (shiftLeft)
				next_st.wreg[shiftIdx] = (shiftAmt > dsc_core_pkg::SHL_MAX) ?
					16'h0 : sw << shiftAmt;
			else
				next_st.wreg[shiftIdx] = 16'($signed(sw) >>>
					((shiftAmt > dsc_core_pkg::SHR_MAX) ?
					dsc_core_pkg::SHR_MAX : shiftAmt));
		end
		// Address generator step: bit-reverse on X dest, else modulo when enabled, else step by one word
		if (aguStep) begin
			p = st.wreg[aguIdx];
			if (st.ctrl[dsc_core_pkg::CT_BREV] && !aguY && aguDest) begin
				m = {<<{p}};
				p = {<<{dsc_core_pkg::WORD_STEP}};
				m = m + p;
				next_st.wreg[aguIdx] = {<<{m}};
			end else if (st.ctrl[aguY ? dsc_core_pkg::CT_MODY :
				dsc_core_pkg::CT_MODX] && p >= st.modEnd) begin
				next_st.wreg[aguIdx] = st.modBeg;
			end else begin
				next_st.wreg[aguIdx] = p + dsc_core_pkg::WORD_STEP;
			end
		end
		// Frame pointer link and unlink by copying between stack and frame pointers
		if (frameLink) begin
			next_st.wreg[dsc_core_pkg::FP_IDX] =
				st.wreg[dsc_core_pkg::SP_IDX];
		end else if (frameUnlink) begin
			next_st.wreg[dsc_core_pkg::SP_IDX] =
				st.wreg[dsc_core_pkg::FP_IDX];
		end
		// Automatic stack pointer moves
		if (callPush || excAck)
			next_st.wreg[dsc_core_pkg::SP_IDX] =
				st.wreg[dsc_core_pkg::SP_IDX] +
				dsc_core_pkg::WORD_STEP;
		else if (retPop)
			next_st.wreg[dsc_core_pkg::SP_IDX] =
				st.wreg[dsc_core_pkg::SP_IDX] -
				dsc_core_pkg::WORD_STEP;
		// Exception entry stacks status low byte and pointer top byte
		if (excAck && st.excReq) begin
			next_st.stackWr = 1'b1;
			next_st.stackWrAddr = st.wreg[dsc_core_pkg::SP_IDX];
			next_st.stackWrData = {st.status[7:0], 1'b0,
				st.ip[22:16]};
			if (!st.excPri[3])
				next_st.status[dsc_core_pkg::ST_PRI +: 3] = st.excPri[2:0];
		end
		// Shadow transfers, no bus path to them
		if (shadowPush) begin
			next_st.shW = st.wreg[3:0];
			next_st.shFlags = st.status & dsc_core_pkg::FLAG_MASK;
		end else if (shadowPop) begin
			next_st.wreg[3:0] = st.shW;
			next_st.status = (st.status & ~dsc_core_pkg::FLAG_MASK)
				| st.shFlags;
		end
		// Hardware loop with shadowed loop registers
		if (loopStart) begin
			next_st.shBegin = st.loopBegin;
			next_st.shEnd = st.loopEnd;
			next_st.shCount = st.loopCount;
			next_st.loopBegin = {loopBeginIn[22:1], 1'b0};
			next_st.loopEnd = {loopEndIn[22:1], 1'b0};
			next_st.loopCount = loopCountIn;
			next_st.status[dsc_core_pkg::ST_DA] = 1'b1;
		end else if (loopDone) begin
			next_st.loopBegin = st.shBegin;
			next_st.loopEnd = st.shEnd;
			next_st.loopCount = st.shCount;
			next_st.status[dsc_core_pkg::ST_DA] = 1'b0;
		end
		// Repeat counter and its running flag
		if (repeatStart) begin
			next_st.repCount = repeatCountIn;
			next_st.status[dsc_core_pkg::ST_RA] = 1'b1;
		end else if (repeatTick && st.status[dsc_core_pkg::ST_RA]) begin
			next_st.repCount = st.repCount - 14'h1;
			if (st.repCount == 14'h0)
				next_st.status[dsc_core_pkg::ST_RA] = 1'b0;
		end
		// Prefetch holds the next word; pointer steps by one word
		if (ipLoad) begin
			next_st.ip = ipLoadVal;
		end else if (fetchStep) begin
			next_st.instrNext = fetchWord;
			next_st.ip = st.ip + dsc_core_pkg::IP_STEP;
		end
		next_st.ip[0] = 1'b0;
		next_st.wreg[dsc_core_pkg::SP_IDX][0] = 1'b0;
		next_st.fetchAddr = {1'b0, next_st.ip[21:0]};
		// Data window: Y split, program visibility, table address
		next_st.dataIsY = dataAddr >= dsc_core_pkg::Y_BASE &&
			dataAddr <= dsc_core_pkg::Y_LAST;
		next_st.psvHit = dataAddr[15] &&
			st.ctrl[dsc_core_pkg::CT_PSV];
		next_st.psvAddr = {st.psvPage, dataAddr[14:0]};
		next_st.tblAddr = {st.tblPage, st.wreg[tblIdx]};
		// Traps first by fixed rank, then interrupts above the level
		for (int i = dsc_core_pkg::NUM_TRAP - 1; i >= 0; i--) begin
			if (trapReq[i]) begin
				found = 1'b1;
				bestPri = dsc_core_pkg::TRAP_TOP - 4'(i);
				bestVec = 6'(i);
			end
		end
		if (!found) begin
			for (int i = dsc_core_pkg::NUM_IRQ - 1; i >= 0; i--) begin
				if (irqReq[i] && st.prio[i] != 3'h0 && {1'b0, st.prio[i]} >=
					bestPri && st.prio[i] >
					st.status[dsc_core_pkg::ST_PRI +: 3]) begin
					found = 1'b1;
					bestPri = {1'b0, st.prio[i]};
					bestVec = 6'(i + dsc_core_pkg::NUM_TRAP);
				end
			end
		end
		next_st.excReq = found;
		next_st.excVector = bestVec;
		next_st.excPri = bestPri;
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			st <= '0;
			st.ready <= 1'b1;
			st.wreg[dsc_core_pkg::SP_IDX] <= dsc_core_pkg::SP_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register, hresp tied low
	assign hrdata = st.rdata;
	assign hreadyout = st.ready;
	assign hresp = 1'b0;
	assign fetchAddr = st.fetchAddr;
	assign instrNext = st.instrNext;
	assign stackWr = st.stackWr;
	assign stackWrAddr = st.stackWrAddr;
	assign stackWrData = st.stackWrData;
	assign dataIsY = st.dataIsY;
	assign psvHit = st.psvHit;
	assign psvAddr = st.psvAddr;
	assign tblAddr = st.tblAddr;
	assign excReq = st.excReq;
	assign excVector = st.excVector;
endmodule

// *** sim/dsc_core_regs_monitor.sv ***
// Purpose: Port assertions for the core register block
// Assumes: One clock domain, rst_n active low
// Notes:   Bound onto every instance of dsc_core_regs
`timescale 1ns/100ps
module dsc_core_regs_monitor (
	// Clock, reset, enable
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        ce,
	// Bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	// Core side
	input wire logic [15:0] dataAddr,
	input wire logic [7:0]  trapReq,
	input wire logic        excAck,
	input wire logic [22:0] fetchAddr,
	input wire logic        stackWr,
	input wire logic [15:0] stackWrAddr,
	input wire logic [15:0] stackWrData,
	input wire logic        psvHit,
	input wire logic        excReq,
	input wire logic [5:0]  excVector
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Accepted bus requests
	logic takeRd;
	logic takeWr;
	assign takeRd = hsel && htrans[1] && hready && ce && !hwrite;
	assign takeWr = hsel && htrans[1] && hready && ce && hwrite;
	a_fetch_even: assert property (fetchAddr[0] == 1'b0)
		else $error("fetch address odd");
	a_fetch_top: assert property (fetchAddr[22] == 1'b0)
		else $error("fetch address top bit set");
	a_stack_even: assert property (stackWr |-> !stackWrAddr[0])
		else $error("stack write misaligned");
	a_push_pulse: assert property (stackWr |=> !stackWr)
		else $error("stack write longer than one cycle");
	a_ack_push: assert property (
		excAck && excReq && ce |-> ##[1:2] stackWr)
		else $error("exception entry without stack write");
	a_push_fmt: assert property (stackWr |-> !stackWrData[7])
		else $error("stacked word bit 7 set");
	a_trap_first: assert property (
		(trapReq != 8'h00 && !excAck)[*3] |-> excReq && excVector < 6'h08)
		else $error("trap not ahead of interrupts");
	a_vec_range: assert property (excReq |-> excVector <= 6'h3D)
		else $error("vector outside 62");
	a_read_wait: assert property (
		takeRd |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_ready: assert property (takeWr |=> hreadyout)
		else $error("write stalled");
	a_psv_upper: assert property (
		(!dataAddr[15])[*2] |-> !psvHit)
		else $error("program window hit below upper half");
	// Main scenarios reached
	c_push: cover property (stackWr);
	c_read: cover property (takeRd);
	c_irq: cover property (excReq && excVector >= 6'h08);
endmodule
bind dsc_core_regs dsc_core_regs_monitor mon (.mclk(mclk), .rst_n(rst_n),
	.ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .dataAddr(dataAddr), .trapReq(trapReq),
	.excAck(excAck), .fetchAddr(fetchAddr), .stackWr(stackWr),
	.stackWrAddr(stackWrAddr), .stackWrData(stackWrData), .psvHit(psvHit),
	.excReq(excReq), .excVector(excVector));

// *** sim/dsc_core_regs_bench.sv ***
// Purpose: Directed bench for the core register block
// Assumes: Bus reads take one wait state, core pulses one cycle
// Notes:   Bus accesses wait on hreadyout; watchdog ends hangs
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
	errorCnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module dsc_core_regs_bench;
	logic mclk, rst_n, ce, hsel, hwrite, coreWr, coreWrByte;
	logic shadowPush, shadowPop, loopStart, loopDone, repeatStart;
	logic repeatTick, callPush, retPop, frameLink, frameUnlink;
	logic shiftReq, shiftLeft, aguStep, aguY, aguDest, fetchStep, ipLoad;
	logic excAck, stackWr, dataIsY, psvHit, excReq, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  coreWrIdx, shiftIdx, aguIdx, tblIdx;
	logic [15:0] coreWrData, dataAddr, stackWrAddr, stackWrData;
	logic [22:0] loopBeginIn, loopEndIn, ipLoadVal, fetchAddr, psvAddr;
	logic [13:0] loopCountIn, repeatCountIn;
	logic [4:0]  shiftAmt;
	logic [23:0] fetchWord, instrNext, tblAddr;
	logic [7:0]  trapReq;
	logic [53:0] irqReq;
	logic [5:0]  excVector;
	logic [31:0] q;
	wire logic   hready;
	int          errorCnt;
	int          checks;
	// Shift cases: direction, amount, start, result
	logic        sl [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic [4:0]  sn [4] = '{5'h10, 5'h0F, 5'h0F, 5'h04};
	logic [15:0] s0 [4] = '{16'h0001, 16'h0001, 16'h8000, 16'h8000};
	logic [15:0] s1 [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'hF800};
	assign hready = hreadyout;
	dsc_core_regs dut (.*);
	// Clock
	always #20 mclk = ~mclk;
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One single AHB-Lite transfer
	task automatic ahb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(a, 1'b0, 32'h0, r);
		`CHK($sformatf("reg %h", a), e, r)
	endtask
	task automatic done(input string s);
		$display("test %s finished, %0d errors", s, errorCnt);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#800000;
		errorCnt++;
		summarize;
	end
	initial begin
		{mclk, rst_n, hsel, hwrite, coreWr, coreWrByte, shadowPush} = '0;
		{shadowPop, loopStart, loopDone, repeatStart, repeatTick} = '0;
		{callPush, retPop, frameLink, frameUnlink, shiftReq} = '0;
		{shiftLeft, aguStep, aguY, aguDest, fetchStep, ipLoad, excAck} = '0;
		{haddr, hwdata, htrans, hsize, coreWrIdx, shiftIdx, aguIdx} = '0;
		{tblIdx, coreWrData, dataAddr, loopBeginIn, loopEndIn} = '0;
		{ipLoadVal, loopCountIn, repeatCountIn, shiftAmt, fetchWord} = '0;
		{trapReq, irqReq} = '0;
		hsize = 3'h2;
		ce = 1'b1;
		idle(20);
		rst_n <= 1'b1;
		idle(3);
		rd(12'h03C, 32'h0800);
		rd(12'h05C, 32'h0);
		rd(12'h0F0, 32'h0);
		done("reset");
		wr(12'h03C, 32'h1235);
		rd(12'h03C, 32'h1234);
		@(posedge mclk) callPush <= 1'b1;
		@(posedge mclk) callPush <= 1'b0;
		rd(12'h03C, 32'h1236);
		@(posedge mclk) frameLink <= 1'b1;
		@(posedge mclk) frameLink <= 1'b0;
		rd(12'h038, 32'h1236);
		@(posedge mclk) retPop <= 1'b1;
		@(posedge mclk) retPop <= 1'b0;
		rd(12'h03C, 32'h1234);
		@(posedge mclk) frameUnlink <= 1'b1;
		@(posedge mclk) frameUnlink <= 1'b0;
		rd(12'h03C, 32'h1236);
		// Enable low freezes the pointer despite a call pulse
		@(posedge mclk) begin
			ce <= 1'b0;
			callPush <= 1'b1;
		end
		@(posedge mclk) begin
			ce <= 1'b1;
			callPush <= 1'b0;
		end
		rd(12'h03C, 32'h1236);
		done("stack");
		wr(12'h05C, 32'h7FFFFF);
		rd(12'h05C, 32'h7FFFFE);
		idle(2);
		`CHK("fetchAddr", 23'h3FFFFE, fetchAddr)
		wr(12'h05C, 32'h0);
		@(posedge mclk) begin
			fetchStep <= 1'b1;
			fetchWord <= 24'hABCDEF;
		end
		@(posedge mclk) fetchStep <= 1'b0;
		idle(3);
		`CHK("instrNext", 24'hABCDEF, instrNext)
		`CHK("fetchAddr", 23'h000002, fetchAddr)
		@(posedge mclk) begin
			ipLoad <= 1'b1;
			ipLoadVal <= 23'h000101;
		end
		@(posedge mclk) ipLoad <= 1'b0;
		rd(12'h05C, 32'h100);
		done("pointer");
		wr(12'h00C, 32'h5500);
		for (int b = 1; b >= 0; b--) begin
			@(posedge mclk) begin
				coreWr <= 1'b1;
				coreWrIdx <= 4'h3;
				coreWrData <= 16'h12AB;
				coreWrByte <= b[0];
			end
			@(posedge mclk) coreWr <= 1'b0;
			rd(12'h00C, b ? 32'h55AB : 32'h12AB);
		end
		// Byte write to the high lane over the bus
		hsize <= 3'h0;
		wr(12'h00D, 32'h7700);
		hsize <= 3'h2;
		rd(12'h00C, 32'h77AB);
		done("byte");
		for (int i = 0; i < 4; i++) begin
			wr(12'(4 * i), 32'h1111 * (i + 1));
		end
		wr(12'h040, 32'h010F);
		@(posedge mclk) shadowPush <= 1'b1;
		@(posedge mclk) shadowPush <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wr(i == 4 ? 12'h040 : 12'(4 * i), 32'h0);
		end
		@(posedge mclk) shadowPop <= 1'b1;
		@(posedge mclk) shadowPop <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(12'(4 * i), 32'h1111 * (i + 1));
		end
		rd(12'h040, 32'h010F);
		done("shadow");
		wr(12'h04C, 32'h100);
		@(posedge mclk) begin
			loopStart <= 1'b1;
			loopBeginIn <= 23'h000200;
			loopEndIn <= 23'h000300;
			loopCountIn <= 14'h0005;
		end
		@(posedge mclk) loopStart <= 1'b0;
		rd(12'h04C, 32'h200);
		rd(12'h040, 32'h030F);
		@(posedge mclk) loopDone <= 1'b1;
		@(posedge mclk) loopDone <= 1'b0;
		rd(12'h04C, 32'h100);
		rd(12'h040, 32'h010F);
		done("loop");
		for (int i = 0; i < 4; i++) begin
			wr(12'h014, {16'h0, s0[i]});
			@(posedge mclk) begin
				shiftReq <= 1'b1;
				shiftIdx <= 4'h5;
				shiftLeft <= sl[i];
				shiftAmt <= sn[i];
			end
			@(posedge mclk) shiftReq <= 1'b0;
			rd(12'h014, {16'h0, s1[i]});
		end
		done("shift");
		// Program window, table address and Y split
		wr(12'h060, 32'h0008);
		wr(12'h048, 32'h0012);
		wr(12'h044, 32'h0034);
		@(posedge mclk) begin
			dataAddr <= 16'h8004;
			tblIdx <= 4'h3;
		end
		idle(2);
		`CHK("psvHit", 1'b1, psvHit)
		`CHK("psvAddr", 23'h090004, psvAddr)
		`CHK("tblAddr", 24'h344444, tblAddr)
		`CHK("dataIsY", 1'b0, dataIsY)
		`CHK("hresp", 1'b0, hresp)
		@(posedge mclk) dataAddr <= 16'h0900;
		idle(2);
		`CHK("dataIsY", 1'b1, dataIsY)
		`CHK("psvHit", 1'b0, psvHit)
		done("window");
		// Modulo wrap in X, then bit-reversed destination step
		wr(12'h064, 32'h0100);
		wr(12'h068, 32'h0104);
		wr(12'h060, 32'h0001);
		wr(12'h018, 32'h0102);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk) begin
				aguStep <= 1'b1;
				aguIdx <= 4'h6;
			end
			@(posedge mclk) aguStep <= 1'b0;
			rd(12'h018, i ? 32'h0100 : 32'h0104);
		end
		wr(12'h060, 32'h0004);
		wr(12'h018, 32'h0002);
		@(posedge mclk) begin
			aguStep <= 1'b1;
			aguDest <= 1'b1;
		end
		@(posedge mclk) aguStep <= 1'b0;
		rd(12'h018, 32'h0001);
		done("agu");
		wr(12'h03C, 32'h0900);
		wr(12'h05C, 32'h0);
		wr(12'h040, 32'h0005);
		@(posedge mclk) trapReq <= 8'h81;
		idle(3);
		`CHK("excVector", 6'h00, excVector)
		@(posedge mclk) trapReq <= 8'h80;
		idle(3);
		`CHK("excVector", 6'h07, excVector)
		@(posedge mclk) trapReq <= 8'h00;
		wr(12'h114, 32'h3);
		wr(12'h124, 32'h3);
		@(posedge mclk) irqReq <= 54'h220;
		idle(3);
		`CHK("excVector", 6'h0D, excVector)
		`CHK("excReq", 1'b1, excReq)
		@(posedge mclk) excAck <= 1'b1;
		@(posedge mclk) excAck <= 1'b0;
		for (int k = 0; k < 4 && stackWr !== 1'b1; k++) begin
			@(posedge mclk);
		end
		`CHK("stackWr", 1'b1, stackWr)
		`CHK("stackWrAddr", 16'h0900, stackWrAddr)
		`CHK("stackWrData", 16'h0500, stackWrData)
		// Level now equals the request's priority, so it is masked
		idle(1);
		`CHK("excReq", 1'b0, excReq)
		@(posedge mclk) irqReq <= '0;
		rd(12'h03C, 32'h0902);
		ahb(12'h040, 1'b0, 32'h0, q);
		`CHK("priority", 3'h3, q[7:5])
		done("exception");
		summarize;
	end
endmodule
